// [pkg/gis_pkg.sv]
// constants and carriers shared by the gyro interface, offset and self-test register bank
package gis_pkg;
  // register map
  localparam logic [7:0] ADDR_IFOPT  = 8'h34;
  localparam logic [7:0] ADDR_OFSLO  = 8'h36;
  localparam logic [7:0] ADDR_OFSX   = 8'h37;
  localparam logic [7:0] ADDR_OFSY   = 8'h38;
  localparam logic [7:0] ADDR_OFSZ   = 8'h39;
  localparam logic [7:0] ADDR_SPARE0 = 8'h3a;
  localparam logic [7:0] ADDR_SPARE1 = 8'h3b;
  localparam logic [7:0] ADDR_BIST   = 8'h3c;
  localparam logic [7:0] RST_BYTE    = 8'h00;
  localparam logic [7:0] MASK_IFOPT  = 8'h37;
  // timing
  localparam int CLK_MHZ      = 50;
  localparam int WDT_SHORT_US = 1000;
  localparam int WDT_LONG_US  = 50000;
  localparam int BIST_RUN_US  = 10;
  localparam int WDT_CNT_W    = 22;
  localparam int BIST_CNT_W   = 10;
  localparam logic [BIST_CNT_W-1:0] BIST_RUN_CYC = BIST_CNT_W'(BIST_RUN_US * CLK_MHZ);
  // accepted self-test reading window
  localparam logic signed [15:0] BIST_LO = 16'shfc00;
  localparam logic signed [15:0] BIST_HI = 16'sh0400;
  localparam logic signed [15:0] DATA_MAX = 16'sh7fff;
  localparam logic signed [15:0] DATA_MIN = 16'sh8000;
  localparam logic [3:0] NVM_EMPTY = 4'h0;

  typedef struct packed {
    logic [1:0] rsv_hi;
    logic       sync_en;
    logic       sync_sel;
    logic       rsv_lo;
    logic       wdt_en;
    logic       wdt_sel;
    logic       three_wire;
  } gis_ifopt_t;

  typedef struct packed {
    logic [1:0] x_32;
    logic [2:0] y_31;
    logic [2:0] z_31;
  } gis_ofs_low_t;

  typedef struct packed {
    logic [3:0] spare_nibble;
    logic [1:0] x_10;
    logic       y_0;
    logic       z_0;
  } gis_spare_lsb_t;

  typedef struct packed {
    logic [2:0] rsv_hi;
    logic       rate_ok;
    logic       rsv_lo;
    logic       fail;
    logic       done;
    logic       running;
  } gis_bist_t;

  // non-volatile image of the offset and spare bytes
  typedef struct packed {
    gis_ofs_low_t   low;
    logic [7:0]     x_up;
    logic [7:0]     y_up;
    logic [7:0]     z_up;
    gis_spare_lsb_t lsb;
    logic [7:0]     spare_octet;
  } gis_nvm_img_t;

  typedef struct packed {
    logic signed [15:0] filt;
    logic signed [15:0] unfilt;
  } gis_axis_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_RUN   = 3'b010,
    ST_CHECK = 3'b100
  } gis_bist_st_t;
endpackage : gis_pkg

// [src/gis_offset_sub.sv]
// per-axis offset subtraction with saturation, registered output
`timescale 1ns/10ps
module gis_offset_sub
  import gis_pkg::*;
(
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // data
  input  wire gis_axis_t          raw,
  input  wire logic signed [11:0] offset,
  output gis_axis_t               comp
);
  function automatic logic signed [15:0] sat_sub(input logic signed [15:0] a,
                                                  input logic signed [11:0] o);
    logic signed [16:0] d;
    d = {a[15], a} - {{5{o[11]}}, o};
    // clip instead of wrapping so a large offset never flips the sign
    if (d[16] != d[15]) sat_sub = d[16] ? DATA_MIN : DATA_MAX;
    else sat_sub = d[15:0];
  endfunction : sat_sub

  always_ff @(posedge clk) begin
    if (!rst_n) comp <= '0;
    else begin
      comp.filt   <= sat_sub(raw.filt, offset);
      comp.unfilt <= sat_sub(raw.unfilt, offset);
    end
  end

  property p_sub_filt;
    @(posedge clk) disable iff (!rst_n)
      1 |=> comp.filt == sat_sub($past(raw.filt), $past(offset));
  endproperty
  a_sub_filt: assert property (p_sub_filt) else $error("filtered offset wrong");
  property p_zero_ofs;
    @(posedge clk) disable iff (!rst_n)
      offset == 12'sh000 |=> comp.unfilt == $past(raw.unfilt);
  endproperty
  a_zero_ofs: assert property (p_zero_ofs) else $error("zero offset altered data");
endmodule : gis_offset_sub

// [src/gis_selftest.sv]
// built-in self-test sequencer: run, judge reading, report done and fail
`timescale 1ns/10ps
module gis_selftest
  import gis_pkg::*;
(
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // control and sensor
  input  wire logic               start,
  input  wire logic signed [15:0] sense,
  // status
  output logic                    running,
  output logic                    done,
  output logic                    fail
);
  gis_bist_st_t            st_r;
  logic [BIST_CNT_W-1:0]   cnt_r;
  logic                    bad;

  assign bad     = (sense < BIST_LO) || (sense > BIST_HI);
  assign running = (st_r != ST_IDLE);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r  <= ST_IDLE;
      cnt_r <= '0;
    end else begin
      unique case (st_r)
        ST_IDLE: begin
          cnt_r <= '0;
          if (start) st_r <= ST_RUN;
        end
        ST_RUN: begin
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r == BIST_RUN_CYC - 1'b1) st_r <= ST_CHECK;
        end
        ST_CHECK: st_r <= ST_IDLE;
        default:  st_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      done <= 1'b0;
      fail <= 1'b0;
    end else if (st_r == ST_CHECK) begin
      done <= 1'b1;
      fail <= bad;
    end else if (start && st_r == ST_IDLE) begin
      done <= 1'b0;
      fail <= 1'b0;
    end
  end

  sequence s_start;
    start && st_r == ST_IDLE;
  endsequence
  sequence s_cleared;
    !done && !fail && running;
  endsequence
  property p_start_clears;
    @(posedge clk) disable iff (!rst_n) s_start |=> s_cleared;
  endproperty
  a_start_clears: assert property (p_start_clears) else $error("start left old result");
  property p_done_in_time;
    @(posedge clk) disable iff (!rst_n) s_start |-> ##[1:600] $rose(done);
  endproperty
  a_done_in_time: assert property (p_done_in_time) else $error("self-test never finished");
  property p_fail_judge;
    @(posedge clk) disable iff (!rst_n) st_r == ST_CHECK |=> done && fail == $past(bad);
  endproperty
  a_fail_judge: assert property (p_fail_judge) else $error("fail flag misjudged");
endmodule : gis_selftest

// [src/gis_regbank.sv]
// gyro interface options, offset compensation, spare bytes and self-test register bank
`timescale 1ns/10ps
module gis_regbank
  import gis_pkg::*;
#(
  parameter logic [WDT_CNT_W-1:0] WDT_SHORT_CYC = WDT_CNT_W'(WDT_SHORT_US * CLK_MHZ),
  parameter logic [WDT_CNT_W-1:0] WDT_LONG_CYC  = WDT_CNT_W'(WDT_LONG_US * CLK_MHZ)
) (
  // clock and reset
  input  wire logic               MCLK,
  input  wire logic               RST_N,
  // register port from the serial front end
  input  wire logic [7:0]         REG_ADDR,
  input  wire logic               REG_WR,
  input  wire logic               REG_RD,
  input  wire logic [7:0]         REG_WDATA,
  output logic [7:0]              REG_RDATA,
  // digital interface options
  input  wire logic               I2C_MODE,
  input  wire logic               SERIAL_DATA_IN_PIN,
  input  wire logic               IRQ_PIN_THREE,
  input  wire logic               IRQ_PIN_FOUR,
  output logic                    EXT_SYNC_ACTIVE,
  output logic                    EXT_SYNC_SRC,
  output logic                    THREE_WIRE_SELECT,
  output logic                    I2C_WDT_EXPIRE,
  // non-volatile memory
  input  wire gis_nvm_img_t       NVM_IMAGE,
  input  wire logic               NVM_LOAD,
  input  wire logic               NVM_UNLOCK,
  input  wire logic [3:0]         NVM_REMAIN,
  input  wire logic               NVM_PROG_TRIG,
  output logic                    NVM_PROG_STROBE,
  output gis_nvm_img_t            NVM_PROG_DATA,
  // sensor data and self-test
  input  wire gis_axis_t [2:0]    RATE_RAW,
  output gis_axis_t [2:0]         RATE_COMP,
  input  wire logic               SENSOR_HEALTHY,
  input  wire logic signed [15:0] BIST_SENSE,
  output logic                    BIST_ACTIVE
);
  gis_ifopt_t            ifopt_r;
  gis_nvm_img_t          img_r;
  logic                  boot_load_r;
  logic                  load_now;
  logic [WDT_CNT_W-1:0]  wdt_cnt_r;
  logic [WDT_CNT_W-1:0]  wdt_limit;
  logic                  wdt_armed;
  logic                  wdt_hit;
  logic                  bist_start;
  logic                  bist_done;
  logic                  bist_fail;
  logic                  bist_run;
  logic                  prog_ok;
  logic signed [11:0]    ofs [3];
  gis_bist_t             bist_view;

  function automatic logic wr_hit(input logic wr, input logic [7:0] a,
                                  input logic [7:0] target);
    wr_hit = wr && (a == target);
  endfunction : wr_hit

  // assembles one axis offset from its upper byte and scattered low bits
  function automatic logic signed [11:0] axis_ofs(input gis_nvm_img_t m,
                                                  input logic [1:0] axis);
    unique case (axis)
      2'h0:    axis_ofs = {m.x_up, m.low.x_32, m.lsb.x_10};
      2'h1:    axis_ofs = {m.y_up, m.low.y_31, m.lsb.y_0};
      default: axis_ofs = {m.z_up, m.low.z_31, m.lsb.z_0};
    endcase
  endfunction : axis_ofs

  // interface options
  always_ff @(posedge MCLK) begin
    if (!RST_N) ifopt_r <= gis_ifopt_t'(RST_BYTE);
    else if (wr_hit(REG_WR, REG_ADDR, ADDR_IFOPT)) begin
      // reserved bits are stored as zero whatever the host sends
      ifopt_r <= gis_ifopt_t'(REG_WDATA & MASK_IFOPT);
    end
  end

  assign EXT_SYNC_ACTIVE   = ifopt_r.sync_en;
  assign EXT_SYNC_SRC      = ifopt_r.sync_sel ? IRQ_PIN_FOUR : IRQ_PIN_THREE;
  assign THREE_WIRE_SELECT = ifopt_r.three_wire;

  // data-line watchdog: counts while the line is held low
  assign wdt_armed = I2C_MODE && ifopt_r.wdt_en;
  assign wdt_limit = ifopt_r.wdt_sel ? WDT_LONG_CYC : WDT_SHORT_CYC;
  assign wdt_hit   = wdt_armed && !SERIAL_DATA_IN_PIN && (wdt_cnt_r == wdt_limit - 1'b1);

  always_ff @(posedge MCLK) begin
    if (!RST_N) wdt_cnt_r <= '0;
    else if (!wdt_armed || SERIAL_DATA_IN_PIN || wdt_hit) wdt_cnt_r <= '0;
    else wdt_cnt_r <= wdt_cnt_r + 1'b1;
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) I2C_WDT_EXPIRE <= 1'b0;
    else I2C_WDT_EXPIRE <= wdt_hit;
  end

  // image reload happens once after reset and on every load trigger
  always_ff @(posedge MCLK) begin
    if (!RST_N) boot_load_r <= 1'b1;
    else boot_load_r <= 1'b0;
  end
  assign load_now = boot_load_r || NVM_LOAD;

  // offset and spare bytes; a host write in the reload cycle wins
  always_ff @(posedge MCLK) begin
    if (!RST_N) img_r <= '0;
    else begin
      if (load_now) img_r <= NVM_IMAGE;
      if (wr_hit(REG_WR, REG_ADDR, ADDR_OFSLO)) img_r.low <= gis_ofs_low_t'(REG_WDATA);
      if (wr_hit(REG_WR, REG_ADDR, ADDR_OFSX)) img_r.x_up <= REG_WDATA;
      if (wr_hit(REG_WR, REG_ADDR, ADDR_OFSY)) img_r.y_up <= REG_WDATA;
      if (wr_hit(REG_WR, REG_ADDR, ADDR_OFSZ)) img_r.z_up <= REG_WDATA;
      if (wr_hit(REG_WR, REG_ADDR, ADDR_SPARE0)) img_r.lsb <= gis_spare_lsb_t'(REG_WDATA);
      if (wr_hit(REG_WR, REG_ADDR, ADDR_SPARE1)) img_r.spare_octet <= REG_WDATA;
    end
  end

  // NVM programming: refused trigger leaves no trace at the ports
  assign prog_ok = NVM_PROG_TRIG && NVM_UNLOCK && (NVM_REMAIN != NVM_EMPTY);

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      NVM_PROG_STROBE <= 1'b0;
      NVM_PROG_DATA   <= '0;
    end else begin
      NVM_PROG_STROBE <= prog_ok;
      if (prog_ok) NVM_PROG_DATA <= img_r;
    end
  end

  // offset compensation per axis
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_axis
      assign ofs[g] = axis_ofs(img_r, 2'(g));
      gis_offset_sub u_sub (
        .clk    (MCLK),
        .rst_n  (RST_N),
        .raw    (RATE_RAW[g]),
        .offset (ofs[g]),
        .comp   (RATE_COMP[g])
      );
    end
  endgenerate

  // self-test: a trigger during a run is ignored
  assign bist_start = wr_hit(REG_WR, REG_ADDR, ADDR_BIST) && REG_WDATA[0];

  gis_selftest u_bist (
    .clk     (MCLK),
    .rst_n   (RST_N),
    .start   (bist_start),
    .sense   (BIST_SENSE),
    .running (bist_run),
    .done    (bist_done),
    .fail    (bist_fail)
  );
  assign BIST_ACTIVE = bist_run;

  always_comb begin
    bist_view         = '0;
    bist_view.rate_ok = SENSOR_HEALTHY;
    bist_view.fail    = bist_fail;
    bist_view.done    = bist_done;
    bist_view.running = bist_run;
  end

  // registered read-back; unmapped addresses read zero
  always_ff @(posedge MCLK) begin
    if (!RST_N) REG_RDATA <= RST_BYTE;
    else if (REG_RD) begin
      unique case (REG_ADDR)
        ADDR_IFOPT:  REG_RDATA <= ifopt_r;
        ADDR_OFSLO:  REG_RDATA <= img_r.low;
        ADDR_OFSX:   REG_RDATA <= img_r.x_up;
        ADDR_OFSY:   REG_RDATA <= img_r.y_up;
        ADDR_OFSZ:   REG_RDATA <= img_r.z_up;
        ADDR_SPARE0: REG_RDATA <= img_r.lsb;
        ADDR_SPARE1: REG_RDATA <= img_r.spare_octet;
        ADDR_BIST:   REG_RDATA <= bist_view;
        default:     REG_RDATA <= RST_BYTE;
      endcase
    end
  end

  // checks
  property p_sync_en;
    @(posedge MCLK) disable iff (!RST_N)
      wr_hit(REG_WR, REG_ADDR, ADDR_IFOPT) |=> EXT_SYNC_ACTIVE == $past(REG_WDATA[5]);
  endproperty
  a_sync_en: assert property (p_sync_en) else $error("sync enable not taken");

  property p_sync_src;
    @(posedge MCLK) disable iff (!RST_N)
      EXT_SYNC_SRC == (ifopt_r.sync_sel ? IRQ_PIN_FOUR : IRQ_PIN_THREE);
  endproperty
  a_sync_src: assert property (p_sync_src) else $error("wrong sync source");

  property p_wdt_quiet;
    @(posedge MCLK) disable iff (!RST_N)
      !$past(wdt_armed) |-> !I2C_WDT_EXPIRE;
  endproperty
  a_wdt_quiet: assert property (p_wdt_quiet) else $error("watchdog fired while off");

  property p_wdt_period;
    @(posedge MCLK) disable iff (!RST_N)
      I2C_WDT_EXPIRE |-> $past(wdt_cnt_r) == $past(wdt_limit) - 1'b1;
  endproperty
  a_wdt_period: assert property (p_wdt_period) else $error("watchdog period wrong");

  property p_wiring;
    @(posedge MCLK) disable iff (!RST_N)
      wr_hit(REG_WR, REG_ADDR, ADDR_IFOPT) |=> THREE_WIRE_SELECT == $past(REG_WDATA[0]);
  endproperty
  a_wiring: assert property (p_wiring) else $error("wiring select not taken");

  property p_ofs_x;
    @(posedge MCLK) disable iff (!RST_N)
      wr_hit(REG_WR, REG_ADDR, ADDR_OFSX) |=> ofs[0][11:4] == $past(REG_WDATA);
  endproperty
  a_ofs_x: assert property (p_ofs_x) else $error("x offset write not applied");

  property p_reload;
    @(posedge MCLK) disable iff (!RST_N)
      load_now && !REG_WR |=> img_r == $past(NVM_IMAGE);
  endproperty
  a_reload: assert property (p_reload) else $error("image not reloaded");

  property p_prog_gate;
    @(posedge MCLK) disable iff (!RST_N)
      NVM_PROG_STROBE |-> $past(NVM_UNLOCK) && $past(NVM_REMAIN) != NVM_EMPTY;
  endproperty
  a_prog_gate: assert property (p_prog_gate) else $error("locked NVM write taken");

  property p_rate_ok;
    @(posedge MCLK) disable iff (!RST_N)
      REG_RD && REG_ADDR == ADDR_BIST |=> REG_RDATA[4] == $past(SENSOR_HEALTHY);
  endproperty
  a_rate_ok: assert property (p_rate_ok) else $error("rate valid flag wrong");

  property p_sync_sel;
    @(posedge MCLK) disable iff (!RST_N)
      wr_hit(REG_WR, REG_ADDR, ADDR_IFOPT) |=> ifopt_r.sync_sel == $past(REG_WDATA[4]);
  endproperty
  a_sync_sel: assert property (p_sync_sel) else $error("sync select not taken");

  property p_wdt_en_bit;
    @(posedge MCLK) disable iff (!RST_N)
      wr_hit(REG_WR, REG_ADDR, ADDR_IFOPT) |=> ifopt_r.wdt_en == $past(REG_WDATA[2]);
  endproperty
  a_wdt_en_bit: assert property (p_wdt_en_bit) else $error("watchdog enable not taken");

  property p_wdt_sel_bit;
    @(posedge MCLK) disable iff (!RST_N)
      wr_hit(REG_WR, REG_ADDR, ADDR_IFOPT) |=> ifopt_r.wdt_sel == $past(REG_WDATA[1]);
  endproperty
  a_wdt_sel_bit: assert property (p_wdt_sel_bit) else $error("watchdog period not taken");

  property p_wdt_count;
    @(posedge MCLK) disable iff (!RST_N)
      wdt_armed && !SERIAL_DATA_IN_PIN && !wdt_hit |=> wdt_cnt_r == $past(wdt_cnt_r) + 1'b1;
  endproperty
  a_wdt_count: assert property (p_wdt_count) else $error("watchdog did not count");

  property p_wdt_release;
    @(posedge MCLK) disable iff (!RST_N)
      SERIAL_DATA_IN_PIN |=> wdt_cnt_r == '0;
  endproperty
  a_wdt_release: assert property (p_wdt_release) else $error("watchdog kept count");

  property p_wdt_pulse;
    @(posedge MCLK) disable iff (!RST_N)
      I2C_WDT_EXPIRE |=> !I2C_WDT_EXPIRE;
  endproperty
  a_wdt_pulse: assert property (p_wdt_pulse) else $error("watchdog pulse too long");

  property p_ofs_y;
    @(posedge MCLK) disable iff (!RST_N)
      wr_hit(REG_WR, REG_ADDR, ADDR_OFSY) |=> ofs[1][11:4] == $past(REG_WDATA);
  endproperty
  a_ofs_y: assert property (p_ofs_y) else $error("y offset write not applied");

  property p_ofs_z;
    @(posedge MCLK) disable iff (!RST_N)
      wr_hit(REG_WR, REG_ADDR, ADDR_OFSZ) |=> ofs[2][11:4] == $past(REG_WDATA);
  endproperty
  a_ofs_z: assert property (p_ofs_z) else $error("z offset write not applied");

  property p_ofs_low;
    @(posedge MCLK) disable iff (!RST_N)
      wr_hit(REG_WR, REG_ADDR, ADDR_OFSLO) |=> ofs[0][3:2] == $past(REG_WDATA[7:6]) &&
        ofs[1][3:1] == $past(REG_WDATA[5:3]) && ofs[2][3:1] == $past(REG_WDATA[2:0]);
  endproperty
  a_ofs_low: assert property (p_ofs_low) else $error("shared offset bits misplaced");

  property p_spare0;
    @(posedge MCLK) disable iff (!RST_N)
      wr_hit(REG_WR, REG_ADDR, ADDR_SPARE0) |=> img_r.lsb == $past(REG_WDATA);
  endproperty
  a_spare0: assert property (p_spare0) else $error("spare nibble write lost");

  property p_spare1;
    @(posedge MCLK) disable iff (!RST_N)
      wr_hit(REG_WR, REG_ADDR, ADDR_SPARE1) |=> img_r.spare_octet == $past(REG_WDATA);
  endproperty
  a_spare1: assert property (p_spare1) else $error("spare octet write lost");

  property p_prog_take;
    @(posedge MCLK) disable iff (!RST_N)
      prog_ok |=> NVM_PROG_STROBE && NVM_PROG_DATA == $past(img_r);
  endproperty
  a_prog_take: assert property (p_prog_take) else $error("accepted NVM write lost");

  property p_bist_go;
    @(posedge MCLK) disable iff (!RST_N)
      bist_start && !bist_run |=> bist_run;
  endproperty
  a_bist_go: assert property (p_bist_go) else $error("self-test did not start");

  property p_read_ifopt;
    @(posedge MCLK) disable iff (!RST_N)
      REG_RD && REG_ADDR == ADDR_IFOPT |=> REG_RDATA == $past(ifopt_r);
  endproperty
  a_read_ifopt: assert property (p_read_ifopt) else $error("options read back wrong");
endmodule : gis_regbank

// [testbench/gis_host.sv]
// host-side driver of the register port
`timescale 1ns/10ps
module gis_host (
  // clock
  input  wire logic       clk,
  // register port
  output logic [7:0]      addr,
  output logic            wr,
  output logic            rd,
  output logic [7:0]      wdata,
  input  wire logic [7:0] rdata
);
  initial begin
    addr  = 8'h00;
    wr    = 1'b0;
    rd    = 1'b0;
    wdata = 8'h00;
  end

  // reserved positions are always sent as zero
  function automatic logic [7:0] keep_mask(input logic [7:0] a);
    case (a)
      8'h34:   return 8'h37;
      8'h3c:   return 8'h01;
      default: return 8'hff;
    endcase
  endfunction : keep_mask

  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    addr  = a;
    wdata = d & keep_mask(a);
    wr    = 1'b1;
    @(posedge clk);
    #1;
    wr    = 1'b0;
    // released data must not look valid
    wdata = ~wdata;
  endtask : write_reg

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    addr = a;
    rd   = 1'b1;
    @(posedge clk);
    #1;
    rd   = 1'b0;
    d    = rdata;
  endtask : read_reg
endmodule : gis_host

// [testbench/gis_regbank_tb.sv]
// self-checking bench of the register bank
`timescale 1ns/10ps
module gis_regbank_tb;
  import gis_pkg::*;
  logic              mclk = 1'b0;
  logic              rst_n = 1'b0;
  logic [7:0]        reg_addr, reg_wdata, reg_rdata, rv;
  logic              reg_wr, reg_rd, i2c_mode, sda, irq3, irq4, sync_act, sync_src, wire3;
  logic              wdt_exp, nvm_load, nvm_unlock, nvm_trig, prog_stb, bist_act, healthy;
  logic [3:0]        nvm_remain;
  gis_nvm_img_t      img, prog_data;
  gis_axis_t [2:0]   raw, comp;
  logic signed [15:0] sense;
  logic [7:0]        sh [52:60];
  int                seed = 27354;
  int                err_count = 0;
  int                n_checks = 0;
  int                n, k;
  logic [15:0]       st_tab [4] = '{16'h0400, 16'h0401, 16'hfc00, 16'hfbff};
  // first offset pass: x at +2047, y at -2048, z at zero
  logic [47:0]       corner = 48'hc07f80000c5a;

  always #10 mclk = ~mclk;

  gis_host gis_host_i (.clk(mclk), .addr(reg_addr), .wr(reg_wr), .rd(reg_rd),
                       .wdata(reg_wdata), .rdata(reg_rdata));

  gis_regbank #(.WDT_SHORT_CYC(22'd8), .WDT_LONG_CYC(22'd20)) gis_regbank_i (
    .MCLK(mclk), .RST_N(rst_n), .REG_ADDR(reg_addr), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .I2C_MODE(i2c_mode),
    .SERIAL_DATA_IN_PIN(sda), .IRQ_PIN_THREE(irq3), .IRQ_PIN_FOUR(irq4),
    .EXT_SYNC_ACTIVE(sync_act), .EXT_SYNC_SRC(sync_src), .THREE_WIRE_SELECT(wire3),
    .I2C_WDT_EXPIRE(wdt_exp), .NVM_IMAGE(img), .NVM_LOAD(nvm_load), .NVM_UNLOCK(nvm_unlock),
    .NVM_REMAIN(nvm_remain), .NVM_PROG_TRIG(nvm_trig), .NVM_PROG_STROBE(prog_stb),
    .NVM_PROG_DATA(prog_data), .RATE_RAW(raw), .RATE_COMP(comp), .SENSOR_HEALTHY(healthy),
    .BIST_SENSE(sense), .BIST_ACTIVE(bist_act));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic tick();
    @(posedge mclk);
    #1;
  endtask : tick

  task automatic tmo();
    err_count++;
    $display("unexpected wait limit reached");
    complete_run();
  endtask : tmo

  function automatic logic signed [11:0] ofs(input int a);
    case (a)
      0:       return {sh[8'h37], sh[8'h36][7:6], sh[8'h3a][3:2]};
      1:       return {sh[8'h38], sh[8'h36][5:3], sh[8'h3a][1]};
      default: return {sh[8'h39], sh[8'h36][2:0], sh[8'h3a][0]};
    endcase
  endfunction : ofs

  // saturating difference, as the data path must not wrap
  function automatic logic signed [15:0] sub_sat(input logic signed [15:0] r, input int a);
    int v = int'(r) - int'(ofs(a));
    if (v > 32767) v = 32767;
    if (v < -32768) v = -32768;
    return 16'(v);
  endfunction : sub_sat

  task automatic wr_sh(input logic [7:0] a, input logic [7:0] d);
    sh[a] = d & gis_host_i.keep_mask(a);
    gis_host_i.write_reg(a, d);
  endtask : wr_sh

  task automatic new_img();
    img = 48'($random(seed)) ^ {$random(seed), 16'h0000};
    for (int a = 8'h36; a <= 8'h3b; a++) sh[a] = img[8*(8'h3b-a) +: 8];
  endtask : new_img

  task automatic read_sh(input logic [7:0] lo, input logic [7:0] hi);
    for (int a = lo; a <= hi; a++) begin
      gis_host_i.read_reg(8'(a), rv);
      check("register", rv, sh[a]);
    end
  endtask : read_sh

  task automatic wdt_gap(output int g);
    for (k = 0; k < 100 && wdt_exp !== 1'b1; k++) tick();
    if (k == 100) tmo();
    g = 0;
    do begin
      tick();
      g++;
    end while (wdt_exp !== 1'b1 && g < 100);
  endtask : wdt_gap

  task automatic wdt_quiet();
    int p = 0;
    repeat (60) begin
      tick();
      if (wdt_exp === 1'b1) p++;
    end
    check("watchdog quiet", p, 0);
  endtask : wdt_quiet

  initial begin
    {i2c_mode, sda, irq3, irq4, nvm_load, nvm_unlock, nvm_trig, healthy} = 8'h40;
    nvm_remain = 4'h0;
    sense = 16'sh0000;
    raw = '0;
    for (int a = 52; a <= 60; a++) sh[a] = 8'h00;
    new_img();
    repeat (6) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    repeat (3) tick();
    read_sh(8'h34, 8'h3b);
    gis_host_i.read_reg(8'h35, rv);
    check("unmapped", rv, 8'h00);
    // interface options and routing of the sync source
    for (int i = 0; i < 6; i++) begin
      {irq3, irq4} = 2'($random(seed));
      wr_sh(8'h34, 8'($random(seed)));
      read_sh(8'h34, 8'h34);
      check("sync on", sync_act, sh[8'h34][5]);
      check("sync src", sync_src, sh[8'h34][4] ? irq4 : irq3);
      check("three wire", wire3, sh[8'h34][0]);
    end
    // offsets: first pass saturates both ends, then random codes
    for (int i = 0; i < 8; i++) begin
      for (int a = 8'h36; a <= 8'h3b; a++) begin
        wr_sh(8'(a), (i == 0) ? corner[8*(8'h3b-a) +: 8] : 8'($random(seed)));
      end
      for (int a = 0; a < 3; a++) raw[a] = (i == 0) ? {16'h8000, 16'h7fff} : $random(seed);
      repeat (3) tick();
      for (int a = 0; a < 3; a++) begin
        check("filt", comp[a].filt, sub_sat(raw[a].filt, a));
        check("unfilt", comp[a].unfilt, sub_sat(raw[a].unfilt, a));
      end
      read_sh(8'h36, 8'h3b);
    end
    // watchdog periods and arming
    i2c_mode = 1'b1;
    sda = 1'b0;
    wr_sh(8'h34, 8'h04);
    wdt_gap(n);
    check("short period", n, 8);
    wr_sh(8'h34, 8'h06);
    wdt_gap(n);
    check("long period", n, 20);
    wr_sh(8'h34, 8'h02);
    wdt_quiet();
    wr_sh(8'h34, 8'h04);
    i2c_mode = 1'b0;
    wdt_quiet();
    sda = 1'b1;
    // program request: accepted, locked, no cycles left
    for (int i = 0; i < 3; i++) begin
      nvm_unlock = (i != 1);
      nvm_remain = (i == 2) ? 4'h0 : 4'h5;
      nvm_trig = 1'b1;
      tick();
      nvm_trig = 1'b0;
      check("prog strobe", prog_stb, i == 0);
      if (i == 0) begin
        check("prog data", prog_data, {sh[8'h36], sh[8'h37], sh[8'h38], sh[8'h39],
                                       sh[8'h3a], sh[8'h3b]});
      end
    end
    // reload from a new image
    new_img();
    nvm_load = 1'b1;
    tick();
    nvm_load = 1'b0;
    read_sh(8'h36, 8'h3b);
    // soft reset mid-run: options clear, the image comes back
    new_img();
    sh[8'h34] = 8'h00;
    rst_n = 1'b0;
    repeat (2) tick();
    rst_n = 1'b1;
    tick();
    read_sh(8'h34, 8'h3b);
    // self-test at both edges of the accepted window
    for (int i = 0; i < 4; i++) begin
      sense = st_tab[i];
      healthy = 1'($random(seed));
      gis_host_i.write_reg(8'h3c, 8'h01);
      gis_host_i.read_reg(8'h3c, rv);
      check("bist busy", rv, {3'b000, healthy, 4'b0001});
      check("bist active", bist_act, 1'b1);
      for (k = 0; k < 700 && bist_act === 1'b1; k++) tick();
      if (k == 700) tmo();
      gis_host_i.read_reg(8'h3c, rv);
      check("bist result", rv, {3'b000, healthy, 1'b0, sense > 1024 || sense < -1024,
                                2'b10});
    end
    complete_run();
  end
endmodule : gis_regbank_tb
